// [common/ioxe_pkg.sv]
// Purpose: Shared constants and types for the indexed offset execute unit
// Assumes: Registers sit on 32-bit Avalon-MM words at byte offsets
// Notes: Every offset, field position, pattern and writable-register reset value lives here
package ioxe_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] IOXE_OFF_CTRL = 6'h00;
  localparam logic [5:0] IOXE_OFF_OPCODE = 6'h04;
  localparam logic [5:0] IOXE_OFF_WREG = 6'h08;
  localparam logic [5:0] IOXE_OFF_FRAME = 6'h0C;
  localparam logic [5:0] IOXE_OFF_BANK = 6'h10;
  localparam logic [5:0] IOXE_OFF_STATUS = 6'h14;
  localparam logic [5:0] IOXE_OFF_EFF = 6'h18;

  // Status register field positions
  localparam int unsigned IOXE_ST_C = 0;
  localparam int unsigned IOXE_ST_DIGIT = 1;
  localparam int unsigned IOXE_ST_Z = 2;
  localparam int unsigned IOXE_ST_OVER = 3;
  localparam int unsigned IOXE_ST_N = 4;
  localparam int unsigned IOXE_ST_BUSY = 8;
  localparam int unsigned IOXE_ST_DONE = 9;
  localparam int unsigned IOXE_ST_ILL = 10;
  localparam int unsigned IOXE_ST_IDX = 11;

  // Reset values
  localparam logic IOXE_EXT_RST = 1'h0;
  localparam logic [7:0] IOXE_WREG_RST = 8'h00;
  localparam logic [11:0] IOXE_FRAME_RST = 12'h000;
  localparam logic [3:0] IOXE_BANK_RST = 4'h0;
  localparam logic [4:0] IOXE_FLAGS_RST = 5'h00;
  localparam logic [15:0] IOXE_OPCODE_RST = 16'h0000;

  // Addressing constants
  localparam logic [7:0] IOXE_INDEX_LIMIT = 8'h5F;
  localparam logic [7:0] IOXE_ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] IOXE_ACCESS_HI_BANK = 4'hF;
  localparam logic [7:0] IOXE_FILL_VALUE = 8'hFF;

  // Opcode upper-bit patterns
  localparam logic [5:0] IOXE_PAT_ADD = 6'h09;
  localparam logic [3:0] IOXE_PAT_BSET = 4'h8;
  localparam logic [6:0] IOXE_PAT_FILL = 7'h34;

  // Phases in one instruction cycle
  localparam int unsigned IOXE_PHASES = 4;

  // Execution sequence, one state per phase
  typedef enum logic [4:0] {
    IOXE_IDLE = 5'h01,
    IOXE_DECODE = 5'h02,
    IOXE_READ = 5'h04,
    IOXE_PROC = 5'h08,
    IOXE_WRITE = 5'h10
  } ioxe_state_e;

  // Decoded instruction class
  typedef enum logic [3:0] {
    IOXE_OP_ADD = 4'h1,
    IOXE_OP_BSET = 4'h2,
    IOXE_OP_FILL = 4'h4,
    IOXE_OP_ILL = 4'h8
  } ioxe_op_e;

endpackage

// [core/ioxe_phase_gen.sv]
// Purpose: Free-running four-phase ring, one clk per phase
// Assumes: Phase one follows reset release
// Notes: Outputs are one-hot enables, never a derived clock
`timescale 1ns/1ns
module ioxe_phase_gen
  import ioxe_pkg::*;
#(
  parameter int unsigned PHASES = IOXE_PHASES
)
(
  input wire logic clk,
  input wire logic arst_n,
  output logic [PHASES-1:0] phase
);

  // Whole state of this module
  typedef struct packed {
    logic [PHASES-1:0] ring;
  } ioxe_phase_s;

  ioxe_phase_s st_reg;
  ioxe_phase_s st_next;

  // Rotate by one each clock
  always_comb
  begin
    st_next = st_reg;
    st_next.ring = {st_reg.ring[PHASES-2:0], st_reg.ring[PHASES-1]};
  end

  // Ring starts at phase one
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg.ring <= {{(PHASES-1){1'b0}}, 1'b1};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign phase = st_reg.ring;

endmodule

// [core/ioxe_exec.sv]
// Purpose: Decode and execute indexed byte and bit instructions
// Assumes: Data memory answers a read one clock after mem_rd
// Notes: Software loads an opcode over Avalon-MM; execution is 4 phases
`timescale 1ns/1ns

// What this block does
// - Small access operands offset the frame pointer
// - Add sums accumulator and indexed byte
// - Destination bit picks accumulator or memory
// - Add updates all five status flags
// - Decode add pattern, one cycle
// - Bit force sets bit b, flags kept
// - Decode bit force pattern, b field
// - Fill writes FFh, flags kept
// - Decode fill pattern, one cycle
// - Decode, read, process, write per phase
// - Enable bit gates extended indexed mode
// - Disabled mode uses access or banked address
// - Pointer plus offset spans 4096 bytes
module ioxe_exec
  import ioxe_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);

  // Whole state of the unit
  typedef struct packed {
    ioxe_state_e state;
    logic pending; // Opcode loaded, waiting for phase one
    logic ext_en; // Extended mode enable
    logic [15:0] opcode;
    ioxe_op_e op;
    logic indexed; // Last operand used frame-pointer offset
    logic [7:0] wreg;
    logic [11:0] fp;
    logic [3:0] bank; // Bank select for banked operands
    logic [4:0] flags;
    logic [4:0] flags_new; // Computed in process, committed in write
    logic done;
    logic illegal;
    logic [11:0] eff_addr;
    logic [7:0] data; // Operand byte caught in process phase
    logic [7:0] result;
    logic ack; // Bus answer pending for next edge
    logic [31:0] rdata;
  } ioxe_exec_s;

  ioxe_exec_s st_reg;
  ioxe_exec_s st_next;
  logic [3:0] phase; // One-hot phase enables
  logic busy; // Instruction queued or running
  logic [8:0] sum9; // Add result with carry
  logic [4:0] sum5; // Low nibble sum for digit carry
  logic [31:0] merged; // Write data merged under byte enables
  logic [31:0] rd_val; // Read mux output
  logic [12:0] ea; // Indexed flag and address from decode

  // Phase ring
  ioxe_phase_gen #(
    .PHASES(IOXE_PHASES)
  ) u_phase (
    .clk(clk),
    .arst_n(arst_n),
    .phase(phase)
  );

  // Classify an opcode by its upper bits
  function automatic ioxe_op_e decode_op(input logic [15:0] op);
    ioxe_op_e r;
    r = IOXE_OP_ILL;
    if (op[15:10] == IOXE_PAT_ADD)
    begin
      r = IOXE_OP_ADD;
    end
    else if (op[15:12] == IOXE_PAT_BSET)
    begin
      r = IOXE_OP_BSET;
    end
    else if (op[15:9] == IOXE_PAT_FILL)
    begin
      r = IOXE_OP_FILL;
    end
    return r;
  endfunction

  // Effective address: {indexed, 12-bit address}
  function automatic logic [12:0] calc_ea(input logic [15:0] op,
                                          input logic ext,
                                          input logic [11:0] fp,
                                          input logic [3:0] bank);
    logic [7:0] k;
    logic a;
    logic [12:0] r;
    k = op[7:0];
    a = op[8];
    if (ext && !a && (k <= IOXE_INDEX_LIMIT))
    begin
      // Wraps within the 4096-byte space
      r = {1'b1, fp + {4'h0, k}};
    end
    else if (!a)
    begin
      // Access bank: low half at bank 0, high half at top bank
      if (k < IOXE_ACCESS_SPLIT)
      begin
        r = {1'b0, 4'h0, k};
      end
      else
      begin
        r = {1'b0, IOXE_ACCESS_HI_BANK, k};
      end
    end
    else
    begin
      r = {1'b0, bank, k};
    end
    return r;
  endfunction

  // Byte-lane merge of a bus write into an old word
  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Writes stall while an instruction is queued or running, so the
  // operand registers cannot shift under an instruction in flight.
  assign busy = (st_reg.state != IOXE_IDLE) || st_reg.pending;

  // Next state: bus slave, then execution sequence
  always_comb
  begin
    st_next = st_reg;
    sum9 = 9'h000;
    sum5 = 5'h00;
    merged = 32'h00000000;
    rd_val = 32'h00000000;
    ea = 13'h0000;

    // Read mux; unmapped addresses read zero
    case (avs_address)
      IOXE_OFF_CTRL: rd_val = {31'h00000000, st_reg.ext_en};
      IOXE_OFF_OPCODE: rd_val = {16'h0000, st_reg.opcode};
      IOXE_OFF_WREG: rd_val = {24'h000000, st_reg.wreg};
      IOXE_OFF_FRAME: rd_val = {20'h00000, st_reg.fp};
      IOXE_OFF_BANK: rd_val = {28'h0000000, st_reg.bank};
      IOXE_OFF_STATUS:
      begin
        rd_val[4:0] = st_reg.flags;
        rd_val[IOXE_ST_BUSY] = busy;
        rd_val[IOXE_ST_DONE] = st_reg.done;
        rd_val[IOXE_ST_ILL] = st_reg.illegal;
        rd_val[IOXE_ST_IDX] = st_reg.indexed;
      end
      IOXE_OFF_EFF: rd_val = {20'h00000, st_reg.eff_addr};
      default: rd_val = 32'h00000000;
    endcase

    // First edge of a request: grant unless a write meets busy
    if (st_reg.ack)
    begin
      st_next.ack = 1'b0;
    end
    else if (avs_read || (avs_write && !busy))
    begin
      st_next.ack = 1'b1;
      st_next.rdata = avs_read ? rd_val : st_reg.rdata;
    end

    // Second edge: write takes effect
    if (avs_write && st_reg.ack)
    begin
      merged = merge_be(rd_val, avs_writedata, avs_byteenable);
      case (avs_address)
        IOXE_OFF_CTRL: st_next.ext_en = merged[0];
        IOXE_OFF_OPCODE:
        begin
          st_next.opcode = merged[15:0];
          st_next.pending = 1'b1;
        end
        IOXE_OFF_WREG: st_next.wreg = merged[7:0];
        IOXE_OFF_FRAME: st_next.fp = merged[11:0];
        IOXE_OFF_BANK: st_next.bank = merged[3:0];
        IOXE_OFF_STATUS:
        begin
          // Flags writable; done and illegal clear on a one
          st_next.flags = merged[4:0];
          if (avs_byteenable[1] && avs_writedata[IOXE_ST_DONE])
          begin
            st_next.done = 1'b0;
          end
          if (avs_byteenable[1] && avs_writedata[IOXE_ST_ILL])
          begin
            st_next.illegal = 1'b0;
          end
        end
        default:
        begin
          // Unmapped write is dropped
        end
      endcase
    end

    // Execution sequence, one state per phase
    unique case (st_reg.state)
      IOXE_IDLE:
      begin
        // Start so that decode lands on phase one
        if (st_reg.pending && phase[3])
        begin
          st_next.pending = 1'b0;
          st_next.state = IOXE_DECODE;
        end
      end
      IOXE_DECODE:
      begin
        // Phase one: classify and form the address
        ea = calc_ea(st_reg.opcode, st_reg.ext_en, st_reg.fp, st_reg.bank);
        st_next.op = decode_op(st_reg.opcode);
        st_next.indexed = ea[12];
        st_next.eff_addr = ea[11:0];
        st_next.state = IOXE_READ;
      end
      IOXE_READ:
      begin
        // Phase two: memory read is issued on mem_rd
        st_next.state = IOXE_PROC;
      end
      IOXE_PROC:
      begin
        // Phase three: operand arrives and is processed
        st_next.data = mem_rdata;
        sum9 = {1'b0, st_reg.wreg} + {1'b0, mem_rdata};
        sum5 = {1'b0, st_reg.wreg[3:0]} + {1'b0, mem_rdata[3:0]};
        unique case (st_reg.op)
          IOXE_OP_ADD:
          begin
            st_next.result = sum9[7:0];
            st_next.flags_new[IOXE_ST_C] = sum9[8];
            st_next.flags_new[IOXE_ST_DIGIT] = sum5[4];
            st_next.flags_new[IOXE_ST_Z] = (sum9[7:0] == 8'h00);
            st_next.flags_new[IOXE_ST_N] = sum9[7];
            st_next.flags_new[IOXE_ST_OVER] =
              (st_reg.wreg[7] == mem_rdata[7]) &&
              (sum9[7] != st_reg.wreg[7]);
          end
          IOXE_OP_BSET:
          begin
            st_next.result =
              mem_rdata | (8'h01 << st_reg.opcode[11:9]);
          end
          IOXE_OP_FILL: st_next.result = IOXE_FILL_VALUE;
          IOXE_OP_ILL: st_next.result = mem_rdata;
          default: st_next.result = mem_rdata;
        endcase
        st_next.state = IOXE_WRITE;
      end
      IOXE_WRITE:
      begin
        // Phase four: commit; frame pointer is never a target
        if (st_reg.op == IOXE_OP_ADD)
        begin
          st_next.flags = st_reg.flags_new;
          if (!st_reg.opcode[9])
          begin
            st_next.wreg = st_reg.result;
          end
        end
        if (st_reg.op == IOXE_OP_ILL)
        begin
          st_next.illegal = 1'b1;
        end
        st_next.done = 1'b1; // Set wins over a same-cycle clear
        st_next.state = IOXE_IDLE;
      end
      default: st_next.state = IOXE_IDLE;
    endcase
  end

  // Register the whole state
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg.state <= IOXE_IDLE;
      st_reg.pending <= 1'b0;
      st_reg.ext_en <= IOXE_EXT_RST;
      st_reg.opcode <= IOXE_OPCODE_RST;
      st_reg.op <= IOXE_OP_ILL;
      st_reg.indexed <= 1'b0;
      st_reg.wreg <= IOXE_WREG_RST;
      st_reg.fp <= IOXE_FRAME_RST;
      st_reg.bank <= IOXE_BANK_RST;
      st_reg.flags <= IOXE_FLAGS_RST;
      st_reg.flags_new <= IOXE_FLAGS_RST;
      st_reg.done <= 1'b0;
      st_reg.illegal <= 1'b0;
      st_reg.eff_addr <= 12'h000;
      st_reg.data <= 8'h00;
      st_reg.result <= 8'h00;
      st_reg.ack <= 1'b0;
      st_reg.rdata <= 32'h00000000;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Bus and memory outputs
  assign avs_waitrequest = (avs_read || avs_write) && !st_reg.ack;
  assign avs_readdata = st_reg.rdata;
  assign mem_addr = st_reg.eff_addr;
  // Illegal opcodes still step through phases but touch no memory
  assign mem_rd = (st_reg.state == IOXE_READ) && (st_reg.op != IOXE_OP_ILL);
  assign mem_wr = (st_reg.state == IOXE_WRITE) &&
                  ((st_reg.op == IOXE_OP_BSET) ||
                   (st_reg.op == IOXE_OP_FILL) ||
                   ((st_reg.op == IOXE_OP_ADD) && st_reg.opcode[9]));
  assign mem_wdata = st_reg.result;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  decode_phase_a: assert property (
    st_reg.state == IOXE_DECODE |-> phase[0] ##3 (st_reg.state == IOXE_WRITE)
  ) else $error("decode not on phase one or write not three later");

  write_phase_a: assert property (
    mem_wr |-> phase[3] && (st_reg.state == IOXE_WRITE)
  ) else $error("memory write outside phase four");

  frame_hold_a: assert property (
    st_reg.state != IOXE_IDLE |=> $stable(st_reg.fp)
  ) else $error("frame pointer changed during execution");

  index_addr_a: assert property (
    (st_reg.state == IOXE_DECODE) && st_reg.ext_en && !st_reg.opcode[8] &&
    (st_reg.opcode[7:0] <= IOXE_INDEX_LIMIT)
    |=> st_reg.indexed && (mem_addr == 12'($past(st_reg.fp) +
        {4'h0, $past(st_reg.opcode[7:0])}))
  ) else $error("indexed address not pointer plus offset");

  literal_addr_a: assert property (
    // Banked operands stay literal in either mode
    (st_reg.state == IOXE_DECODE) && st_reg.opcode[8]
    |=> !st_reg.indexed &&
        (mem_addr == {$past(st_reg.bank), $past(st_reg.opcode[7:0])})
  ) else $error("banked literal address wrong");

  ext_gate_a: assert property (
    (st_reg.state == IOXE_READ) && !st_reg.ext_en |-> !st_reg.indexed
  ) else $error("indexed mode used while disabled");

  add_sum_a: assert property (
    (st_reg.state == IOXE_WRITE) && (st_reg.op == IOXE_OP_ADD)
    |-> st_reg.result == 8'(st_reg.wreg + st_reg.data)
  ) else $error("add result is not accumulator plus operand");

  add_dest_a: assert property (
    (st_reg.state == IOXE_WRITE) && (st_reg.op == IOXE_OP_ADD) &&
    !st_reg.opcode[9] |-> !mem_wr ##1 (st_reg.wreg == $past(st_reg.result))
  ) else $error("add to accumulator went wrong");

  add_flags_a: assert property (
    (st_reg.state == IOXE_WRITE) && (st_reg.op == IOXE_OP_ADD)
    |=> (st_reg.flags[IOXE_ST_Z] == (st_reg.result == 8'h00)) &&
        (st_reg.flags[IOXE_ST_N] == st_reg.result[7])
  ) else $error("add flags do not match result");

  bit_force_a: assert property (
    mem_wr && (st_reg.op == IOXE_OP_BSET)
    |-> mem_wdata == (st_reg.data | (8'h01 << st_reg.opcode[11:9]))
  ) else $error("bit force wrote wrong byte");

  fill_ones_a: assert property (
    mem_wr && (st_reg.op == IOXE_OP_FILL) |-> mem_wdata == 8'hFF
  ) else $error("fill did not write all ones");

  flags_keep_a: assert property (
    (st_reg.state == IOXE_WRITE) && (st_reg.op != IOXE_OP_ADD)
    |=> $stable(st_reg.flags)
  ) else $error("flags changed by a flag-neutral instruction");

  add_mem_c: cover property (mem_wr && (st_reg.op == IOXE_OP_ADD));
  bset_idx_c: cover property (mem_wr && (st_reg.op == IOXE_OP_BSET) &&
                              st_reg.indexed);
  fill_lit_c: cover property (mem_wr && (st_reg.op == IOXE_OP_FILL) &&
                              !st_reg.indexed);
  stall_c: cover property (avs_write && avs_waitrequest && busy);

endmodule

// [verif/ioxe_mem_model.sv]
// Purpose: Data memory partner on the far side of the execute unit
// Assumes: One read strobe gives data in the following cycle
// Notes: Between answers the read bus toggles so data one cycle stale never matches
`timescale 1ns/1ns
module ioxe_mem_model
(
  input wire logic clk,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  // Full 4096-byte data space, preloaded by the bench
  logic [7:0] mem [4096];

  // Known level at time zero
  initial mem_rdata = 8'h00;

  // Byte write on strobe; read answer valid only in the next cycle
  always @(posedge clk)
  begin
    if (mem_wr === 1'b1)
      mem[mem_addr] <= mem_wdata;
    // Inverted when idle, so a late sample is caught
    if (mem_rd === 1'b1)
      mem_rdata <= mem[mem_addr];
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule

// [verif/ioxe_exec_bench.sv]
// Purpose: Self-checking bench for the indexed execute unit
// Assumes: Registers reached over Avalon-MM, memory via partner model
// Notes: Table rows cover the plain cases; edge cases follow the loop
`timescale 1ns/1ns
`define IOXE_CHK(nm, ex, sn) \
  begin \
    tests_run++; \
    if ((sn) !== (ex)) \
    begin \
      err_count++; \
      $display("mismatch %s expected %0h seen %0h", nm, ex, sn); \
    end \
  end
module ioxe_exec_bench
  import ioxe_pkg::*;
;
  // One table row: setup, opcode, expected outcome
  typedef struct packed {
    logic ext;
    logic [11:0] fp;
    logic [3:0] bnk;
    logic [7:0] w;
    logic [15:0] op;
    logic [4:0] fi;
    logic [11:0] ea;
    logic ix;
    logic [7:0] pre;
    logic [7:0] m;
    logic [7:0] wx;
    logic [4:0] fo;
  } ioxe_row_s;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] mem_addr;
  logic mem_rd;
  logic mem_wr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int rd_cnt = 0;
  int wr_cnt = 0;
  int rd_cyc = 0;
  int rd0;
  int wr0;
  logic [31:0] st;
  logic [31:0] rv;
  ioxe_row_s r;
  // Reset view of every mapped register, plus one unmapped word
  logic [5:0] offs [8] = '{IOXE_OFF_CTRL, IOXE_OFF_OPCODE, IOXE_OFF_WREG,
    IOXE_OFF_FRAME, IOXE_OFF_BANK, IOXE_OFF_STATUS, IOXE_OFF_EFF, 6'h1C};
  // ext fp bnk w op fi ea ix pre m wx fo
  ioxe_row_s rows [10] = '{
    '{1'h1, 12'hA00, 4'h0, 8'h17, 16'h242C, 5'h1F, 12'hA2C, 1'h1, 8'h20,
      8'h20, 8'h37, 5'h00},
    '{1'h1, 12'hFF0, 4'h0, 8'h80, 16'h265F, 5'h00, 12'h04F, 1'h1, 8'h80,
      8'h00, 8'h80, 5'h0D},
    '{1'h1, 12'h123, 4'h0, 8'h7F, 16'h2600, 5'h00, 12'h123, 1'h1, 8'h01,
      8'h80, 8'h7F, 5'h1A},
    '{1'h1, 12'hA00, 4'h0, 8'h33, 16'h8E0A, 5'h0A, 12'hA0A, 1'h1, 8'h55,
      8'hD5, 8'h33, 5'h0A},
    '{1'h1, 12'hA00, 4'h0, 8'h33, 16'h800B, 5'h15, 12'hA0B, 1'h1, 8'hF0,
      8'hF1, 8'h33, 5'h15},
    '{1'h1, 12'hA00, 4'h0, 8'h33, 16'h682C, 5'h1F, 12'hA2C, 1'h1, 8'h00,
      8'hFF, 8'h33, 5'h1F},
    '{1'h0, 12'hA00, 4'h0, 8'h33, 16'h682C, 5'h00, 12'h02C, 1'h0, 8'h12,
      8'hFF, 8'h33, 5'h00},
    '{1'h1, 12'hA00, 4'h0, 8'h33, 16'h6860, 5'h00, 12'h060, 1'h0, 8'h12,
      8'hFF, 8'h33, 5'h00},
    '{1'h0, 12'hA00, 4'h0, 8'h33, 16'h8690, 5'h00, 12'hF90, 1'h0, 8'h00,
      8'h08, 8'h33, 5'h00},
    '{1'h1, 12'hA00, 4'h5, 8'h33, 16'h6910, 5'h00, 12'h510, 1'h0, 8'h00,
      8'hFF, 8'h33, 5'h00}};

  ioxe_exec ioxe_exec_inst (.clk(clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  ioxe_mem_model ioxe_mem_model_inst (.clk(clk), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));

  // 100 ns period
  always #50 clk = ~clk;

  // Cycle count; the ceiling cuts a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      stop_test();
    end
  end

  // Strobes are sampled mid-cycle, clear of the edge updates
  always @(negedge clk)
  begin
    if (mem_rd === 1'b1)
    begin
      rd_cnt++;
      rd_cyc = cyc;
    end
    if (mem_wr === 1'b1)
    begin
      wr_cnt++;
      `IOXE_CHK("read to write gap", 2, cyc - rd_cyc)
    end
  end

  // Master: hold request until waitrequest is low at a rising edge
  task automatic bus_xfer(input logic wr, input logic [5:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    begin
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      // Waitrequest and read data seen here are what this edge samples
      do
      begin
        @(posedge clk);
        n++;
      end while (avs_waitrequest !== 1'b0 && n < 300);
      if (avs_waitrequest !== 1'b0)
        `IOXE_CHK("bus answer", 1, 0)
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // Let one edge pass so the next request is a fresh assignment
      @(posedge clk);
    end
  endtask

  task automatic bus_write(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask

  task automatic bus_read(input logic [5:0] a, output logic [31:0] q);
    bus_xfer(1'b0, a, 32'h0, q);
  endtask

  // Start an instruction and poll until it completes or is refused
  task automatic run_op(input logic [15:0] op);
    int n;
    begin
      n = 0;
      st = 32'h0;
      rd0 = rd_cnt;
      wr0 = wr_cnt;
      bus_write(IOXE_OFF_OPCODE, {16'h0, op});
      while ((st[IOXE_ST_DONE] | st[IOXE_ST_ILL]) !== 1'b1 && n < 40)
      begin
        bus_read(IOXE_OFF_STATUS, st);
        n++;
      end
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // Reset values, unmapped word reads zero
    foreach (offs[i])
    begin
      bus_read(offs[i], rv);
      `IOXE_CHK("reset value", 32'h0, rv)
    end
    $display("test reset values done");
    // Table of ordinary cases
    foreach (rows[i])
    begin
      r = rows[i];
      ioxe_mem_model_inst.mem[r.ea] = r.pre;
      bus_write(IOXE_OFF_CTRL, {31'h0, r.ext});
      bus_write(IOXE_OFF_FRAME, {20'h0, r.fp});
      bus_write(IOXE_OFF_BANK, {28'h0, r.bnk});
      bus_write(IOXE_OFF_WREG, {24'h0, r.w});
      bus_write(IOXE_OFF_STATUS, {27'h30, r.fi});
      run_op(r.op);
      `IOXE_CHK("flags", r.fo, st[4:0])
      `IOXE_CHK("indexed", r.ix, st[IOXE_ST_IDX])
      `IOXE_CHK("busy", 1'b0, st[IOXE_ST_BUSY])
      `IOXE_CHK("reads", 1, rd_cnt - rd0)
      `IOXE_CHK("writes", (r.op[15:9] == 7'h12) ? 0 : 1, wr_cnt - wr0)
      `IOXE_CHK("memory", r.m, ioxe_mem_model_inst.mem[r.ea])
      bus_read(IOXE_OFF_EFF, rv);
      `IOXE_CHK("address", r.ea, rv[11:0])
      bus_read(IOXE_OFF_WREG, rv);
      `IOXE_CHK("accumulator", r.wx, rv[7:0])
      bus_read(IOXE_OFF_FRAME, rv);
      `IOXE_CHK("frame pointer", r.fp, rv[11:0])
      $display("test row %0d done", i);
    end
    // Near miss of the fill pattern is refused, no memory traffic
    bus_write(IOXE_OFF_STATUS, 32'h600);
    run_op(16'h6A2C);
    `IOXE_CHK("illegal flag", 1'b1, st[IOXE_ST_ILL])
    `IOXE_CHK("illegal traffic", 0, rd_cnt - rd0 + wr_cnt - wr0)
    $display("test illegal opcode done");
    // Two fills back to back: the second write stalls until the first ends
    bus_write(IOXE_OFF_CTRL, 32'h1);
    bus_write(IOXE_OFF_STATUS, 32'h600);
    ioxe_mem_model_inst.mem[12'hA01] = 8'h00;
    ioxe_mem_model_inst.mem[12'hA02] = 8'h00;
    bus_write(IOXE_OFF_OPCODE, 32'h6801);
    run_op(16'h6802);
    // Done is still set by the first fill, so wait for idle instead
    for (int n = 0; n < 20 && st[IOXE_ST_BUSY] !== 1'b0; n++)
      bus_read(IOXE_OFF_STATUS, st);
    `IOXE_CHK("second idle", 1'b0, st[IOXE_ST_BUSY])
    `IOXE_CHK("first fill", 8'hFF, ioxe_mem_model_inst.mem[12'hA01])
    `IOXE_CHK("second fill", 8'hFF, ioxe_mem_model_inst.mem[12'hA02])
    $display("test back to back done");
    // Reset in mid-run clears the registers again
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus_read(IOXE_OFF_FRAME, rv);
    `IOXE_CHK("frame after reset", 32'h0, rv)
    bus_read(IOXE_OFF_CTRL, rv);
    `IOXE_CHK("mode after reset", 32'h0, rv)
    $display("test second reset done");
    stop_test();
  end
endmodule
